// ===== hw/wdog_window_pkg.sv
// Constants and types shared by the windowed watchdog status block
// What this block does
// - Read-only 8-bit status: window, armed, prescale top
// - Five-bit window counter steps across each period
// - Window code 111 leaves the whole range open
// - Codes 110/101/100 close below 4, 8, 12
// - Codes 011/010 close below 16 and 20
// - Codes 001/000 close below 24 and 28
// - Status bit 2 shows the armed state
// - Status bits 1:0 carry prescale count top bits
// - Prescale count is 18 bits over three registers
// - Prescale reads return the live count
// - Window code sits in control 1 bits 2:0
// - Prescale select scales by powers of two
// - Software run bit counts only when config is 01
package wdog_window_pkg;

   // Register offsets on the byte-wide register port
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_CTRL0 = 12'hED2;
   localparam logic [11:0] OFS_CTRL1 = 12'hED3;
   localparam logic [11:0] OFS_PSC_LOW = 12'hED4;
   localparam logic [11:0] OFS_PSC_HIGH = 12'hED5;
   localparam logic [11:0] OFS_STATUS = 12'hED6;
   localparam logic [11:0] OFS_EVENT = 12'hED7;
   localparam logic [11:0] OFS_MASK = 12'hED8;
   localparam logic [11:0] OFS_CLEAR = 12'hED9;

   // Field positions
   localparam int CTRL0_RUN_BIT = 0;
   localparam int CTRL0_PS_LSB = 1;
   localparam int CTRL1_CS_LSB = 4;
   localparam int CTRL1_WIN_LSB = 0;
   localparam int EVT_TIMEOUT = 0;
   localparam int EVT_VIOLATION = 1;
   localparam int EVT_CLEARED = 2;

   // Codes and reset values
   localparam logic [4:0] PS_UNLOCKED = 5'h1F;
   localparam logic [4:0] PS_DEFAULT = 5'h0B;
   localparam logic [4:0] PS_MAX_CODE = 5'h12;
   localparam logic [2:0] CS_UNLOCKED = 3'h7;
   localparam logic [2:0] CS_LOW_OSC = 3'h0;
   localparam logic [2:0] CS_MID_OSC = 3'h1;
   localparam logic [2:0] WIN_UNLOCKED = 3'h7;
   localparam logic [2:0] WIN_FULL_OPEN = 3'h7;
   localparam logic [1:0] EN_SOFTWARE = 2'h1;
   localparam logic [4:0] WCOUNT_LAST = 5'h1F;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Controller states, one-hot
   typedef enum logic [2:0] {
      ST_LOAD = 3'b001,
      ST_IDLE = 3'b010,
      ST_RUN = 3'b100
   } state_t;

   // Whole state of the block
   typedef struct packed {
      state_t state;
      logic [2:0] lf_sync;
      logic [2:0] mf_sync;
      logic [4:0] ps_sel;
      logic run_bit;
      logic [2:0] clk_sel;
      logic [2:0] win_sel;
      logic [17:0] prescale_count;
      logic [4:0] wcount;
      logic armed;
      logic [2:0] evt;
      logic [2:0] mask;
      logic wdt_reset;
      logic irq;
      logic [7:0] rd_data;
   } wdog_state_t;

endpackage

// ===== hw/wdog_window.sv
// Windowed watchdog window tracking, status readback and register port
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module wdog_window (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [11:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   input wire logic low_freq_osc,
   input wire logic mid_freq_osc,
   input wire logic [1:0] enable_config_field,
   input wire logic [4:0] cfg_prescale,
   input wire logic [2:0] cfg_clock_sel,
   input wire logic [2:0] cfg_window,
   output logic wdt_reset,
   output logic irq
);

   // First counter value of the open region for a window code
   function automatic logic [4:0] open_start(input logic [2:0] win);
      logic [4:0] inv;
      inv = {2'h0, ~win};
      open_start = (win == wdog_window_pkg::WIN_FULL_OPEN) ? 5'h00 : 5'(inv << 2);
   endfunction

   // Prescale terminal count; reserved codes fall back to the shortest step
   function automatic logic [17:0] step_limit(input logic [4:0] ps);
      logic [18:0] one;
      one = 19'h00001;
      if (ps > wdog_window_pkg::PS_MAX_CODE) begin
         step_limit = 18'h00000;
      end else begin
         step_limit = 18'((one << ps) - one);
      end
   endfunction

   wdog_window_pkg::wdog_state_t s_r; // Registered state
   wdog_window_pkg::wdog_state_t s_nxt; // Next state

   logic lf_edge; // Rising edge of low oscillator
   logic mf_edge; // Rising edge of mid oscillator
   logic tick; // One watchdog clock tick
   logic running; // Watchdog enabled by config or software
   logic is_open; // Counter sits in the open region
   logic terminal; // Prescaler at its last count
   logic clr_cmd; // Software clear command
   logic [2:0] evt_set; // Events raised this cycle

   // Edge detect reads only the second and third sync stages
   assign lf_edge = s_r.lf_sync[1] & ~s_r.lf_sync[2];
   assign mf_edge = s_r.mf_sync[1] & ~s_r.mf_sync[2];

   // Oscillator choice; reserved codes give no ticks at all
   always_comb begin
      unique case (s_r.clk_sel)
         wdog_window_pkg::CS_LOW_OSC: tick = lf_edge;
         wdog_window_pkg::CS_MID_OSC: tick = mf_edge;
         default: tick = 1'b0;
      endcase
   end

   // Only config 01 defers to the software bit; 1x forces on, 00 off
   assign running = enable_config_field[1] |
      ((enable_config_field == wdog_window_pkg::EN_SOFTWARE) & s_r.run_bit);

   assign is_open = s_r.wcount >= open_start(s_r.win_sel);
   assign terminal = s_r.prescale_count == step_limit(s_r.ps_sel);
   assign clr_cmd = wr_en && (addr == wdog_window_pkg::OFS_CLEAR);

   // Next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      evt_set = 3'h0;
      s_nxt.wdt_reset = 1'b0;
      // Two-stage synchronisers plus edge history
      s_nxt.lf_sync = {s_r.lf_sync[1:0], low_freq_osc};
      s_nxt.mf_sync = {s_r.mf_sync[1:0], mid_freq_osc};

      unique case (s_r.state)
         wdog_window_pkg::ST_LOAD: begin
            // Capture configuration one edge after reset release
            s_nxt.win_sel = cfg_window;
            s_nxt.clk_sel = (cfg_clock_sel == wdog_window_pkg::CS_UNLOCKED) ?
               wdog_window_pkg::CS_LOW_OSC : cfg_clock_sel;
            s_nxt.ps_sel = (cfg_prescale == wdog_window_pkg::PS_UNLOCKED) ?
               wdog_window_pkg::PS_DEFAULT : cfg_prescale;
            s_nxt.state = wdog_window_pkg::ST_IDLE;
         end
         wdog_window_pkg::ST_IDLE: begin
            // Held at zero while disabled
            s_nxt.prescale_count = 18'h00000;
            s_nxt.wcount = 5'h00;
            s_nxt.armed = 1'b0;
            if (running) begin
               s_nxt.state = wdog_window_pkg::ST_RUN;
               s_nxt.armed = 1'b1;
            end
         end
         wdog_window_pkg::ST_RUN: begin
            if (!running) begin
               s_nxt.state = wdog_window_pkg::ST_IDLE;
               s_nxt.armed = 1'b0;
               s_nxt.prescale_count = 18'h00000;
               s_nxt.wcount = 5'h00;
            end else if (clr_cmd) begin
               // Clear wins over a tick in the same cycle
               s_nxt.prescale_count = 18'h00000;
               s_nxt.wcount = 5'h00;
               if (is_open) begin
                  evt_set[wdog_window_pkg::EVT_CLEARED] = 1'b1;
               end else begin
                  s_nxt.wdt_reset = 1'b1;
                  evt_set[wdog_window_pkg::EVT_VIOLATION] = 1'b1;
               end
            end else if (tick) begin
               if (!terminal) begin
                  s_nxt.prescale_count = s_r.prescale_count + 18'h00001;
               end else begin
                  s_nxt.prescale_count = 18'h00000;
                  s_nxt.wcount = s_r.wcount + 5'h01;
                  // Period runs out when the window counter wraps
                  if (s_r.wcount == wdog_window_pkg::WCOUNT_LAST) begin
                     s_nxt.wdt_reset = 1'b1;
                     evt_set[wdog_window_pkg::EVT_TIMEOUT] = 1'b1;
                  end
               end
            end
         end
         default: begin
            // Illegal one-hot code recovers through a reload
            s_nxt.state = wdog_window_pkg::ST_LOAD;
         end
      endcase

      // Control writes; locked fields ignore software
      if (wr_en && (addr == wdog_window_pkg::OFS_CTRL0)) begin
         s_nxt.run_bit = wr_data[wdog_window_pkg::CTRL0_RUN_BIT];
         if (cfg_prescale == wdog_window_pkg::PS_UNLOCKED) begin
            s_nxt.ps_sel = wr_data[wdog_window_pkg::CTRL0_PS_LSB +: 5];
         end
      end
      if (wr_en && (addr == wdog_window_pkg::OFS_CTRL1)) begin
         if (cfg_clock_sel == wdog_window_pkg::CS_UNLOCKED) begin
            s_nxt.clk_sel = wr_data[wdog_window_pkg::CTRL1_CS_LSB +: 3];
         end
         if (cfg_window == wdog_window_pkg::WIN_UNLOCKED) begin
            s_nxt.win_sel = wr_data[wdog_window_pkg::CTRL1_WIN_LSB +: 3];
         end
      end
      if (wr_en && (addr == wdog_window_pkg::OFS_MASK)) begin
         s_nxt.mask = wr_data[2:0];
      end

      // Event bits: a read clears, a new event in that cycle survives
      if (rd_en && (addr == wdog_window_pkg::OFS_EVENT)) begin
         s_nxt.evt = evt_set;
      end else begin
         s_nxt.evt = s_r.evt | evt_set;
      end
      s_nxt.irq = |(s_nxt.evt & s_r.mask);

      // Read data stands in the cycle after the strobe only
      s_nxt.rd_data = 8'h00;
      if (rd_en) begin
         unique case (addr)
            wdog_window_pkg::OFS_CTRL0:
               s_nxt.rd_data = {2'h0, s_r.ps_sel, s_r.run_bit};
            wdog_window_pkg::OFS_CTRL1:
               s_nxt.rd_data = {1'b0, s_r.clk_sel, 1'b0, s_r.win_sel};
            wdog_window_pkg::OFS_PSC_LOW:
               s_nxt.rd_data = s_r.prescale_count[7:0];
            wdog_window_pkg::OFS_PSC_HIGH:
               s_nxt.rd_data = s_r.prescale_count[15:8];
            wdog_window_pkg::OFS_STATUS:
               s_nxt.rd_data = {s_r.wcount, s_r.armed, s_r.prescale_count[17:16]};
            wdog_window_pkg::OFS_EVENT:
               s_nxt.rd_data = {5'h00, s_r.evt};
            wdog_window_pkg::OFS_MASK:
               s_nxt.rd_data = {5'h00, s_r.mask};
            default:
               s_nxt.rd_data = 8'h00;
         endcase
      end
   end

   // Single state register; everything clears to zero on reset except the state, which loads ST_LOAD
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.state <= wdog_window_pkg::ST_LOAD;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data = s_r.rd_data;
   assign wdt_reset = s_r.wdt_reset;
   assign irq = s_r.irq;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence closed_clear_s;
      (s_r.state == wdog_window_pkg::ST_RUN) && running && clr_cmd && !is_open;
   endsequence

   sequence open_clear_s;
      (s_r.state == wdog_window_pkg::ST_RUN) && running && clr_cmd && is_open;
   endsequence

   status_layout_a: assert property (
      rd_en && (addr == wdog_window_pkg::OFS_STATUS) |=>
      (rd_data[7:3] == $past(s_r.wcount)) && (rd_data[1:0] == $past(s_r.prescale_count[17:16])))
      else $error("status read layout wrong");

   window_step_a: assert property (
      (s_r.state == wdog_window_pkg::ST_RUN) && running && !clr_cmd && tick && terminal
      && (s_r.wcount != 5'h1F) |=> s_r.wcount == $past(s_r.wcount) + 5'h01)
      else $error("window counter did not step");

   full_open_a: assert property (
      s_r.win_sel == 3'h7 |-> is_open)
      else $error("code 111 not fully open");

   closed_bound_a: assert property (
      (s_r.win_sel == 3'h4) |-> (is_open == (s_r.wcount >= 5'h0C)))
      else $error("code 100 boundary wrong");

   half_bound_a: assert property (
      (s_r.win_sel == 3'h3) |-> (is_open == (s_r.wcount >= 5'h10)))
      else $error("code 011 boundary wrong");

   narrow_bound_a: assert property (
      (s_r.win_sel == 3'h0) |-> (is_open == (s_r.wcount >= 5'h1C)))
      else $error("code 000 boundary wrong");

   closed_clear_a: assert property (
      closed_clear_s |=> wdt_reset && (s_r.wcount == 5'h00) ##1 !wdt_reset)
      else $error("closed clear gave no reset pulse");

   open_clear_a: assert property (
      open_clear_s |=> !wdt_reset && (s_r.wcount == 5'h00) && (s_r.prescale_count == 18'h00000))
      else $error("open clear did not restart");

   // Disable drops the armed flag on the very next edge
   armed_off_a: assert property (
      !running |=> !s_r.armed)
      else $error("armed while disabled");

   psc_read_a: assert property (
      rd_en && (addr == wdog_window_pkg::OFS_PSC_LOW) |=> rd_data == $past(s_r.prescale_count[7:0]))
      else $error("prescale low read wrong");

   reserved_ps_a: assert property (
      (s_r.state == wdog_window_pkg::ST_RUN) && running && !clr_cmd && tick
      && (s_r.ps_sel > 5'h12) |=> s_r.prescale_count == 18'h00000)
      else $error("reserved prescale not minimal");

   no_clock_a: assert property (
      (s_r.clk_sel > 3'h1) && !clr_cmd && running && (s_r.state == wdog_window_pkg::ST_RUN)
      |=> $stable(s_r.prescale_count))
      else $error("reserved clock select counted");

   disabled_zero_a: assert property (
      (enable_config_field == 2'h0) [*2] |=> (s_r.wcount == 5'h00) && (s_r.prescale_count == 18'h00000))
      else $error("counters move while disabled");

   // One counted oscillator tick with nothing overriding it
   sequence count_tick_s;
      (s_r.state == wdog_window_pkg::ST_RUN) && running && !clr_cmd && tick;
   endsequence

   // Prescaler steps by one below its terminal count
   prescale_step_a: assert property (
      count_tick_s ##0 !terminal |=> s_r.prescale_count == $past(s_r.prescale_count) + 18'h00001)
      else $error("prescaler did not step");

   // Wrap from the last window value is a timeout
   timeout_wrap_a: assert property (
      count_tick_s ##0 terminal && (s_r.wcount == wdog_window_pkg::WCOUNT_LAST)
      |=> wdt_reset && (s_r.wcount == 5'h00) && s_r.evt[wdog_window_pkg::EVT_TIMEOUT])
      else $error("window wrap gave no timeout");

   // Armed flag reaches bit 2 of the status byte
   status_armed_a: assert property (
      rd_en && (addr == wdog_window_pkg::OFS_STATUS) |=> rd_data[2] == $past(s_r.armed))
      else $error("armed bit missing from status");

   // Middle prescale byte is live on its own read
   psc_high_a: assert property (
      rd_en && (addr == wdog_window_pkg::OFS_PSC_HIGH) |=> rd_data == $past(s_r.prescale_count[15:8]))
      else $error("prescale high read wrong");

   // Read data falls back to zero without a strobe
   read_idle_a: assert property (
      !rd_en |=> rd_data == 8'h00)
      else $error("read data without a strobe");

   // Status byte leaves reset as all zeros
   reset_clear_a: assert property (
      (s_r.state == wdog_window_pkg::ST_LOAD)
      |-> ({s_r.wcount, s_r.armed, s_r.prescale_count[17:16]} == wdog_window_pkg::STATUS_RESET))
      else $error("status not zero after reset");

   // Window code comes from configuration at load; an unlocked write in that cycle wins
   window_load_a: assert property (
      (s_r.state == wdog_window_pkg::ST_IDLE)
      && ($past(s_r.state) == wdog_window_pkg::ST_LOAD) && !$past(wr_en)
      |-> s_r.win_sel == $past(cfg_window))
      else $error("window code not loaded");

   // Event bits after a read hold only this cycle's events
   event_clear_a: assert property (
      rd_en && (addr == wdog_window_pkg::OFS_EVENT) |=> s_r.evt == $past(evt_set))
      else $error("event read did not clear");

   // Accepted clear inside the open region is recorded
   clear_event_a: assert property (
      open_clear_s |=> s_r.evt[wdog_window_pkg::EVT_CLEARED])
      else $error("open clear not recorded");

   // Early clear is recorded as a window violation
   violation_event_a: assert property (
      closed_clear_s |=> s_r.evt[wdog_window_pkg::EVT_VIOLATION])
      else $error("closed clear not recorded");

   // Enabled watchdog arms one edge after idle
   armed_on_a: assert property (
      (s_r.state == wdog_window_pkg::ST_IDLE) && running |=> s_r.armed)
      else $error("watchdog did not arm");

   // Software bit low in mode 01 keeps it disarmed
   run_bit_a: assert property (
      (enable_config_field == wdog_window_pkg::EN_SOFTWARE) && !s_r.run_bit
      && (s_r.state == wdog_window_pkg::ST_IDLE) |=> !s_r.armed)
      else $error("armed with software bit low");

   // Mid oscillator alone drives ticks when selected
   mid_select_a: assert property (
      (s_r.clk_sel == wdog_window_pkg::CS_MID_OSC) |-> (tick == mf_edge))
      else $error("mid oscillator not selected");

endmodule // wdog_window

`default_nettype wire

// ===== bench/wdog_window_bench.sv
// Self-checking bench for the windowed watchdog status block
`timescale 1ns/100ps
`default_nettype none

module wdog_window_bench;
   logic ref_clk = 1'b0; // 200 MHz system clock
   logic rst_n = 1'b0; // Async reset, low active
   logic [11:0] addr = 12'h000;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] rd_data;
   logic low_freq_osc = 1'b0; // Oscillators idle low between ticks
   logic mid_freq_osc = 1'b0;
   logic [1:0] enable_config_field = 2'h0;
   logic [2:0] cfg_window = 3'h7; // Window code from configuration
   logic wdt_reset;
   logic irq;
   int failures = 0;
   int check_count = 0;
   int pulse_count = 0; // Reset requests seen so far
   int model_w; // Model window position
   int open_at; // Model first open window value
   int base; // Pulse tally before a clear
   logic [7:0] got;

   // Clock generator, 5 ns period
   always #2.5 ref_clk = ~ref_clk;

   // Prescale and clock config left writable; cfg_window stays writable until the last test locks it
   wdog_window u_dut (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .addr(addr),
      .wr_data(wr_data),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .rd_data(rd_data),
      .low_freq_osc(low_freq_osc),
      .mid_freq_osc(mid_freq_osc),
      .enable_config_field(enable_config_field),
      .cfg_prescale(5'h1F),
      .cfg_clock_sel(3'h7),
      .cfg_window(cfg_window),
      .wdt_reset(wdt_reset),
      .irq(irq)
   );

   // Tally reset request pulses; latency is not fixed here
   always @(posedge ref_clk) begin
      if (wdt_reset === 1'b1) begin
         pulse_count <= pulse_count + 1;
      end
   end

   // Compare and report
   task chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask

   // One-cycle write strobe
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask

   // One-cycle read strobe, data taken in the following cycle
   task rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   // Oscillator rising edges, slow enough for the synchroniser
   task tick(input int n, input logic mid);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         if (mid) mid_freq_osc <= 1'b1;
         else low_freq_osc <= 1'b1;
         repeat (4) @(posedge ref_clk);
         low_freq_osc <= 1'b0;
         mid_freq_osc <= 1'b0;
         repeat (4) @(posedge ref_clk);
      end
   endtask

   // Verdict, reached from the main sequence or the watchdog
   task end_of_test;
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Hang guard, well beyond the expected run of about 11 us
   initial begin
      #200000;
      failures++;
      end_of_test;
   end

   // Main sequence
   initial begin
      base = $urandom(32'hDC258470);
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h00);
      rd(wdog_window_pkg::OFS_PSC_LOW, got);
      chk(got, 8'h00);
      rd(12'hEDF, got);
      chk(got, 8'h00);
      // Status is read only
      wr(wdog_window_pkg::OFS_STATUS, 8'hFF);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h00);
      // Software run bit only counts in config mode 01
      enable_config_field <= 2'h1;
      wr(wdog_window_pkg::OFS_CTRL0, 8'h00);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h00);
      wr(wdog_window_pkg::OFS_CTRL0, 8'h01);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h04);
      enable_config_field <= 2'h0;
      repeat (2) @(posedge ref_clk);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h00);
      // Live prescale count: select 2, two edges in
      enable_config_field <= 2'h2;
      wr(wdog_window_pkg::OFS_CTRL0, 8'h04);
      wr(wdog_window_pkg::OFS_CLEAR, 8'($urandom));
      tick(2, 1'b0);
      rd(wdog_window_pkg::OFS_PSC_LOW, got);
      chk(got, 8'h02);
      rd(wdog_window_pkg::OFS_PSC_HIGH, got);
      chk(got, 8'h00);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h04);
      // Fourth edge at select 2 rolls into window step one
      tick(2, 1'b0);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h0C);
      wr(wdog_window_pkg::OFS_CTRL0, 8'h00);
      wr(wdog_window_pkg::OFS_MASK, 8'h02);
      // Every window code: a random closed value where one exists (none for 111), then the first open value
      for (int code = 0; code < 8; code++) begin
         open_at = (code == 7) ? 0 : (7 - code) * 4;
         wr(wdog_window_pkg::OFS_CTRL1, {1'b0, 3'(code % 2), 1'b0, 3'(code)});
         for (int t = 0; t < 2; t++) begin
            if (t == 0 && open_at == 0) continue;
            model_w = (t == 0) ? $urandom % open_at : open_at;
            wr(wdog_window_pkg::OFS_CLEAR, 8'h00);
            rd(wdog_window_pkg::OFS_EVENT, got);
            tick(model_w, code % 2 == 1);
            // The unselected oscillator must not advance anything
            tick(1, code % 2 == 0);
            rd(wdog_window_pkg::OFS_STATUS, got);
            chk(got, {5'(model_w), 3'b100});
            base = pulse_count;
            wr(wdog_window_pkg::OFS_CLEAR, 8'($urandom));
            repeat (3) @(posedge ref_clk);
            chk(8'(pulse_count - base), (t == 0) ? 8'h01 : 8'h00);
            chk({7'h00, irq}, (t == 0) ? 8'h01 : 8'h00);
            rd(wdog_window_pkg::OFS_EVENT, got);
            chk(got, (t == 0) ? 8'h02 : 8'h04);
            chk({7'h00, irq}, 8'h00);
            rd(wdog_window_pkg::OFS_STATUS, got);
            chk(got, 8'h04);
         end
      end
      // Reserved clock code: neither oscillator advances anything
      wr(wdog_window_pkg::OFS_CTRL1, 8'h27);
      tick(1, 1'b0);
      tick(1, 1'b1);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h04);
      // Full window run wraps and times out; reserved prescale is the shortest step
      wr(wdog_window_pkg::OFS_CTRL0, 8'h3E);
      wr(wdog_window_pkg::OFS_CTRL1, 8'h07);
      wr(wdog_window_pkg::OFS_CLEAR, 8'h00);
      rd(wdog_window_pkg::OFS_EVENT, got);
      base = pulse_count;
      tick(32, 1'b0);
      repeat (3) @(posedge ref_clk);
      chk(8'(pulse_count - base), 8'h01);
      rd(wdog_window_pkg::OFS_EVENT, got);
      chk(got, 8'h01);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h04);
      // Mid-run reset with the window code locked by configuration
      cfg_window <= 3'h4;
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      wr(wdog_window_pkg::OFS_CTRL1, 8'h07);
      rd(wdog_window_pkg::OFS_CTRL1, got);
      chk(got, 8'h04);
      rd(wdog_window_pkg::OFS_STATUS, got);
      chk(got, 8'h04);
      base = pulse_count;
      wr(wdog_window_pkg::OFS_CLEAR, 8'h00);
      repeat (3) @(posedge ref_clk);
      chk(8'(pulse_count - base), 8'h01);
      end_of_test;
   end
endmodule // wdog_window_bench

`default_nettype wire
